// >>> pkg/irq_prox_regs.vh
// register offsets, fields, reset values and priority level counts of the interrupt status block
`ifndef IRQ_PROX_REGS_VH
`define IRQ_PROX_REGS_VH

`define STAT_ADDR        8'h00
`define RELOAD_ADDR      8'h04
`define CTRL_ADDR        8'h08
`define COUNT_ADDR       8'h0C

`define PRI_LSB          8
`define PRI_MSB          10
`define VEC_LSB          0
`define VEC_MSB          5

`define CTRL_MVEC_BIT    0
`define CTRL_PROX_PRI_LSB 4
`define CTRL_PROX_PRI_MSB 6

`define RELOAD_RST       32'h0000_0000
`define CTRL_RST         32'h0000_0000

`define N_PRI_LEVELS     7
`define N_SUB_LEVELS     4

`endif

// >>> rtl/irq_arbiter.v
// combinational arbiter that picks the highest priority pending source
`timescale 1ns/1ps
module irq_arbiter #(
	parameter N_SRC = 8
) (
	input  wire [N_SRC-1:0]   pend_i,
	input  wire [3*N_SRC-1:0] pri_i,
	input  wire [2*N_SRC-1:0] sub_i,
	output reg                any_o,
	output reg  [5:0]         vec_o,
	output reg  [2:0]         pri_o
);
	integer i;
	reg [4:0] best_key;
	reg [4:0] key;

	// priority 0 means disabled; ties go to the lowest source number
	always @* begin
		best_key = 5'h00;
		any_o = 1'b0;
		vec_o = 6'h00;
		pri_o = 3'h0;
		key = 5'h00;
		for (i = 0; i < N_SRC; i = i + 1) begin
			key = {pri_i[3*i +: 3], sub_i[2*i +: 2]};
			if (pend_i[i] && (pri_i[3*i +: 3] != 3'h0) && (key > best_key)) begin
				best_key = key;
				any_o = 1'b1;
				vec_o = i[5:0];
				pri_o = pri_i[3*i +: 3];
			end
		end
	end
endmodule // irq_arbiter

// >>> rtl/prox_timer.v
// proximity countdown timer, reloaded on a trigger event
`timescale 1ns/1ps
module prox_timer (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        trig_i,
	input  wire [31:0] reload_i,
	output reg  [31:0] count_o,
	output wire        busy_o
);
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= 32'h0000_0000;
		end else if (trig_i) begin
			count_o <= reload_i;
		end else if (count_o != 32'h0000_0000) begin
			count_o <= count_o - 32'h0000_0001;
		end
	end

	assign busy_o = (count_o != 32'h0000_0000);
endmodule // prox_timer

// >>> rtl/irq_status_prox.v
// interrupt prioritiser with presented-vector status and proximity hold-off timer
//
// How it works
// - status bits 10:8 show priority of latest interrupt given to the CPU
// - status bits 5:0 show vector number now presented to the CPU
// - status bits 31:11 and 7:6 always read zero
// - 32-bit read/write reload register, zero after reset
// - an interrupt event triggering the timer loads it from the reload register
// - single and multi vector modes, seven priorities, four subpriorities each
// - sources are prioritised here before a request reaches the CPU
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "irq_prox_regs.vh"
module irq_status_prox #(
	parameter N_SRC = 8
) (
	input  wire               MCLK_I,
	input  wire               RST_N_I,
	input  wire [7:0]         ADDR_I,
	input  wire [31:0]        WDATA_I,
	input  wire               WR_I,
	input  wire               RD_I,
	output reg  [31:0]        RDATA_O,
	input  wire [N_SRC-1:0]   SRC_PEND_I,
	input  wire [3*N_SRC-1:0] SRC_PRI_I,
	input  wire [2*N_SRC-1:0] SRC_SUB_I,
	output reg                CPU_REQ_O,
	output reg  [5:0]         CPU_VEC_O,
	output reg  [2:0]         CPU_PRI_O,
	output wire               MULTI_VEC_O
);
	reg  [31:0] proximity_reload_value_q;
	reg  [31:0] ctrl_q;
	reg  [2:0]  requested_priority_level_q;
	reg  [5:0]  presented_vector_number_q;
	reg         any_prev_q;
	wire        any;
	wire [5:0]  win_vec;
	wire [2:0]  win_pri;
	wire [31:0] count;
	wire        busy;
	wire        qualifies;
	wire        trig;
	wire        release_req;
	reg  [31:0] rdata_d;

	irq_arbiter #(.N_SRC(N_SRC)) u_arb (
		.pend_i (SRC_PEND_I),
		.pri_i  (SRC_PRI_I),
		.sub_i  (SRC_SUB_I),
		.any_o  (any),
		.vec_o  (win_vec),
		.pri_o  (win_pri)
	);

	// a request at or below the programmed threshold waits for the timer;
	// threshold zero disables the hold-off entirely
	assign qualifies = (win_pri <= ctrl_q[`CTRL_PROX_PRI_MSB:`CTRL_PROX_PRI_LSB]);
	assign trig = any && !any_prev_q && qualifies && !busy;
	assign release_req = any && !(qualifies && (busy || trig));
	assign MULTI_VEC_O = ctrl_q[`CTRL_MVEC_BIT];

	prox_timer u_tmr (
		.clk_i    (MCLK_I),
		.rst_n_i  (RST_N_I),
		.trig_i   (trig),
		.reload_i (proximity_reload_value_q),
		.count_o  (count),
		.busy_o   (busy)
	);

	always @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			proximity_reload_value_q <= `RELOAD_RST;
			ctrl_q <= `CTRL_RST;
		end else if (WR_I) begin
			if (ADDR_I == `RELOAD_ADDR) begin
				proximity_reload_value_q <= WDATA_I;
			end
			if (ADDR_I == `CTRL_ADDR) begin
				ctrl_q <= {25'h0, WDATA_I[6:4], 3'h0, WDATA_I[0]};
			end
		end
	end

	// presentation to the CPU; the status fields keep the last one shown
	always @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			any_prev_q <= 1'b0;
			CPU_REQ_O <= 1'b0;
			CPU_VEC_O <= 6'h00;
			CPU_PRI_O <= 3'h0;
			requested_priority_level_q <= 3'h0;
			presented_vector_number_q <= 6'h00;
		end else begin
			any_prev_q <= any;
			CPU_REQ_O <= release_req;
			if (release_req) begin
				CPU_VEC_O <= win_vec;
				CPU_PRI_O <= win_pri;
				presented_vector_number_q <= win_vec;
				requested_priority_level_q <= win_pri;
			end
		end
	end

	// fields are meaningful only in single-vector mode, software's concern
	always @* begin
		rdata_d = 32'h0000_0000;
		case (ADDR_I)
			`STAT_ADDR: begin
				rdata_d[`PRI_MSB:`PRI_LSB] = requested_priority_level_q;
				rdata_d[`VEC_MSB:`VEC_LSB] = presented_vector_number_q;
			end
			`RELOAD_ADDR: rdata_d = proximity_reload_value_q;
			`CTRL_ADDR: rdata_d = ctrl_q;
			`COUNT_ADDR: rdata_d = count;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 32'h0000_0000;
		end else if (RD_I) begin
			RDATA_O <= rdata_d;
		end else begin
			RDATA_O <= 32'h0000_0000;
		end
	end
endmodule // irq_status_prox

// >>> verification/cpu_model.sv
// cpu side model that latches the vector of each taken request in single-vector mode
`timescale 1ns/1ps
module cpu_model (
	input  logic       clk_i,
	input  logic       req_i,
	input  logic       mvec_i,
	input  logic [5:0] vec_i,
	output logic [5:0] last_vec_o = 6'h00
);
	// vector trusted only in single-vector mode
	always @(posedge clk_i) if (req_i && !mvec_i) last_vec_o <= vec_i;
endmodule // cpu_model

// >>> verification/irq_chk_assertions.sv
// assertion checker for the interrupt status block
`timescale 1ns/1ps
`include "irq_prox_regs.vh"
module irq_chk (
	input logic        MCLK_I,
	input logic        RST_N_I,
	input logic [7:0]  ADDR_I,
	input logic [31:0] WDATA_I,
	input logic        WR_I,
	input logic        RD_I,
	input logic [31:0] RDATA_O,
	input logic        CPU_REQ_O,
	input logic [5:0]  CPU_VEC_O,
	input logic [2:0]  CPU_PRI_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence stat_rd; RD_I && ADDR_I == `STAT_ADDR; endsequence
	sequence wr_rd; WR_I && ADDR_I == `RELOAD_ADDR ##1 RD_I && ADDR_I == `RELOAD_ADDR; endsequence
	a_stat_zero_bits: assert property (stat_rd |=> RDATA_O[31:11] == 0 && RDATA_O[7:6] == 0)
		else $error("status reserved bits set");
	a_stat_pri_field: assert property (stat_rd |=> RDATA_O[10:8] == $past(CPU_PRI_O))
		else $error("status priority field wrong");
	a_stat_vec_field: assert property (stat_rd |=> RDATA_O[5:0] == $past(CPU_VEC_O))
		else $error("status vector field wrong");
	a_reload_read_back: assert property (wr_rd |=> RDATA_O == $past(WDATA_I, 2))
		else $error("reload readback wrong");
	a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == 0)
		else $error("read data outside read cycle");
	a_req_pri_valid: assert property (CPU_REQ_O |-> CPU_PRI_O != 0)
		else $error("request with priority zero");
	a_vec_hold_idle: assert property (!CPU_REQ_O |-> $stable(CPU_VEC_O) && $stable(CPU_PRI_O))
		else $error("vector moved without request");
endmodule // irq_chk
bind irq_status_prox irq_chk chk (.*);

// >>> verification/testbench.sv
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "irq_prox_regs.vh"
module testbench;
	logic        MCLK_I = 0, RST_N_I = 0, WR_I = 0, RD_I = 0;
	logic [7:0]  ADDR_I = 0, SRC_PEND_I = 0;
	logic [31:0] WDATA_I = 0;
	logic [23:0] SRC_PRI_I = 0;
	logic [15:0] SRC_SUB_I = 0;
	wire  [31:0] RDATA_O;
	wire         CPU_REQ_O, MULTI_VEC_O;
	wire  [5:0]  CPU_VEC_O, last_vec;
	wire  [2:0]  CPU_PRI_O;
	int          err_count = 0, n_tests = 0, cyc = 0;
	irq_status_prox uut (.*);
	cpu_model cpu (.clk_i(MCLK_I), .req_i(CPU_REQ_O), .mvec_i(MULTI_VEC_O), .vec_i(CPU_VEC_O),
		.last_vec_o(last_vec));
	always #12.5 MCLK_I = ~MCLK_I;
	always @(posedge MCLK_I) if (++cyc > 2000) begin
		err_count++;
		print_verdict();
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
			err_count++;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge MCLK_I);
		{WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
		@(posedge MCLK_I);
		WR_I <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge MCLK_I);
		{RD_I, ADDR_I} <= {1'b1, a};
		@(posedge MCLK_I);
		RD_I <= 0;
		#1 chk(RDATA_O, e);
	endtask
	task wr_rd(input [31:0] d);
		@(posedge MCLK_I);
		{WR_I, ADDR_I, WDATA_I} <= {1'b1, `RELOAD_ADDR, d};
		@(posedge MCLK_I);
		{WR_I, RD_I} <= 2'b01;
		@(posedge MCLK_I);
		RD_I <= 0;
		#1 chk(RDATA_O, d);
	endtask
	task t_regs;
		rd(`RELOAD_ADDR, 0);
		wr_rd(32'h5A3C_F00F);
		wr(`RELOAD_ADDR, 32'hA5C3_0FF1);
		rd(`RELOAD_ADDR, 32'hA5C3_0FF1);
		wr(`STAT_ADDR, 32'hFFFF_FFFF);
		rd(`STAT_ADDR, 0);
		rd(8'h10, 0);
		$display("register test done");
	endtask
	task t_direct;
		SRC_PRI_I <= 24'h03_0003;
		SRC_PEND_I <= 8'h21;
		repeat (3) @(posedge MCLK_I);
		chk(last_vec, 5);
		rd(`STAT_ADDR, 32'h605);
		wr(`CTRL_ADDR, 1);
		#1 chk(MULTI_VEC_O, 1);
		SRC_PEND_I <= 0;
		$display("direct test done");
	endtask
	task t_hold;
		wr(`CTRL_ADDR, 32'h70);
		wr(`RELOAD_ADDR, 3);
		repeat (3) @(posedge MCLK_I);
		SRC_PEND_I <= 8'h01;
		repeat (4) @(posedge MCLK_I);
		#1 chk(CPU_REQ_O, 0);
		@(posedge MCLK_I);
		#1 chk(CPU_REQ_O, 1);
		rd(`STAT_ADDR, 32'h300);
		$display("hold test done");
	endtask
	task t_sub;
		wr(`CTRL_ADDR, 0);
		@(posedge MCLK_I);
		SRC_PRI_I <= 24'h00_0120;
		SRC_SUB_I <= 16'h0030;
		SRC_PEND_I <= 8'h06;
		@(posedge MCLK_I);
		@(posedge MCLK_I);
		#1 chk(CPU_VEC_O, 2);
		chk(CPU_PRI_O, 4);
		$display("subpriority test done");
	endtask
	initial begin
		repeat (3) @(posedge MCLK_I);
		RST_N_I <= 1;
		t_regs();
		t_direct();
		t_hold();
		t_sub();
		print_verdict();
	end
endmodule // testbench
